/* hdl/ppr_pkg.sv */
/*
 * Constants for the peripheral pin route multiplexer: register indices,
 * field positions, route codes and the pin tables of every signal.
 * Assumes pins are numbered PA0..PA7 as 0..7, PB as 8..15, PC as 16..23.
 */
package ppr_pkg;

   // ************************************************************
   // Register map.
   // ************************************************************
   localparam int         PPR_NREGS   = 6;
   localparam int         PPR_DATA_W  = 32;
   localparam int         PPR_REG_W   = 8;
   localparam int         PPR_NPINS   = 24;
   localparam logic [2:0] REG_EVENT_OUTPUT_ROUTE = 3'h0;
   localparam logic [2:0] REG_LOGIC_TABLE_ROUTE  = 3'h1;
   localparam logic [2:0] REG_SERIAL_PORT_ROUTE  = 3'h2;
   localparam logic [2:0] REG_SPI_ROUTE          = 3'h3;
   localparam logic [2:0] REG_TIMER_A_ROUTE      = 3'h4;
   localparam logic [2:0] REG_TIMER_B_ROUTE      = 3'h5;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] REG_MASK [PPR_NREGS] = '{8'h03, 8'h0f, 8'h0f, 8'h03, 8'h3f, 8'h03};
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // Fields and route codes.
   // ************************************************************
   localparam int         SER_FIELD_W   = 2;
   localparam int         SPI_LSB       = 0;
   localparam int         N_TMRA        = 6;
   localparam logic [1:0] ROUTE_DEFAULT = 2'h0;
   localparam logic [1:0] ROUTE_ALT     = 2'h1;
   localparam logic [1:0] ROUTE_NONE    = 2'h3;
   localparam int         SIG_TX = 0;
   localparam int         SIG_RX = 1;
   localparam int         SIG_CK = 2;
   localparam int         SIG_DIR = 3;

   // ************************************************************
   // Pin identities.
   // ************************************************************
   typedef logic [4:0] ppr_pin_t;
   localparam ppr_pin_t PA0 = 5'h00;
   localparam ppr_pin_t PA1 = 5'h01;
   localparam ppr_pin_t PA2 = 5'h02;
   localparam ppr_pin_t PA3 = 5'h03;
   localparam ppr_pin_t PA4 = 5'h04;
   localparam ppr_pin_t PA5 = 5'h05;
   localparam ppr_pin_t PA7 = 5'h07;
   localparam ppr_pin_t PB0 = 5'h08;
   localparam ppr_pin_t PB1 = 5'h09;
   localparam ppr_pin_t PB2 = 5'h0a;
   localparam ppr_pin_t PB3 = 5'h0b;
   localparam ppr_pin_t PB4 = 5'h0c;
   localparam ppr_pin_t PB5 = 5'h0d;
   localparam ppr_pin_t PB6 = 5'h0e;
   localparam ppr_pin_t PB7 = 5'h0f;
   localparam ppr_pin_t PC0 = 5'h10;
   localparam ppr_pin_t PC1 = 5'h11;
   localparam ppr_pin_t PC2 = 5'h12;
   localparam ppr_pin_t PC3 = 5'h13;
   localparam ppr_pin_t PC4 = 5'h14;
   localparam ppr_pin_t PC5 = 5'h15;

   // Tables are indexed [position][signal], SER_PINS [port][position][signal], LUT_IN_PINS [table][input]; position 0 is default.
   localparam ppr_pin_t EV_PINS [2][2] = '{'{PA2, PB2}, '{PA7, PB7}};
   localparam ppr_pin_t LUT_OUT_PINS [2][4] = '{'{PA4, PA7, PB3, PC4}, '{PB4, PC1, PB6, PA5}};
   localparam ppr_pin_t LUT_IN_PINS [4][3] = '{'{PA0, PA1, PA2}, '{PC3, PC4, PC5},
                                              '{PB0, PB1, PB2}, '{PC0, PC1, PC2}};
   localparam ppr_pin_t SER_PINS [2][2][4] = '{'{'{PB2, PB3, PB1, PB0}, '{PA1, PA2, PA3, PA4}},
                                              '{'{PA1, PA2, PA3, PA4}, '{PC2, PC1, PC0, PC3}}};
   localparam ppr_pin_t SPI_PINS [2][4] = '{'{PA1, PA2, PA3, PA4}, '{PC2, PC1, PC0, PC3}};
   localparam ppr_pin_t TMRA_PINS [2][N_TMRA] = '{'{PB0, PB1, PB2, PA3, PA4, PA5},
                                                 '{PB3, PB4, PB5, PC3, PC4, PC5}};
   localparam ppr_pin_t TMRB_PINS [2][2] = '{'{PA5, PA3}, '{PC0, PC4}};

   typedef struct packed {
      logic       hit;
      logic [2:0] idx;
   } ppr_dec_t;

   function automatic ppr_dec_t ppr_decode(input logic [31:0] a);
      ppr_dec_t d;
      d.hit = (a[31:2] < 30'(PPR_NREGS));
      d.idx = a[4:2];
      return d;
   endfunction : ppr_decode

   function automatic logic [PPR_NPINS-1:0] ppr_set(input logic [PPR_NPINS-1:0] v,
                                                    input ppr_pin_t id, input logic b);
      logic [PPR_NPINS-1:0] r;
      r     = v;
      r[id] = b;
      return r;
   endfunction : ppr_set

endpackage : ppr_pkg

/* hdl/ppr_axil_slave.sv */
/*
 * AXI4-Lite slave holding the six routing registers, one per word.
 * Assumes a single clock and a master that keeps valid and payload stable.
 */
module ppr_axil_slave
   import ppr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Write channels.
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [PPR_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // Read channels.
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [PPR_DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Routing registers.
   output logic [PPR_NREGS-1:0][7:0]  route
);

   typedef struct packed {
      logic                     aw_full;
      logic [ADDR_W-1:0]        awaddr;
      logic                     w_full;
      logic [PPR_DATA_W-1:0]    wdata;
      logic                     wlane0;
      logic                     awready;
      logic                     wready;
      logic                     bvalid;
      logic [1:0]               bresp;
      logic                     arready;
      logic                     rvalid;
      logic [PPR_DATA_W-1:0]    rdata;
      logic [1:0]               rresp;
      logic [PPR_NREGS-1:0][7:0] regs;
   } ppr_slv_t;

   ppr_slv_t st;
   ppr_slv_t next_st;

   always_comb begin
      ppr_dec_t d;
      d       = '0;
      next_st = st;
      if (s_axi_awvalid && st.awready) begin
         next_st.aw_full = 1'b1;
         next_st.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.w_full = 1'b1;
         next_st.wdata  = s_axi_wdata;
         next_st.wlane0 = s_axi_wstrb[0];
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // A write lands once both halves are held.
      if (next_st.aw_full && next_st.w_full && !st.bvalid) begin
         d = ppr_decode(32'(next_st.awaddr));
         if (d.hit && next_st.wlane0) begin
            next_st.regs[d.idx] = next_st.wdata[7:0] & REG_MASK[d.idx];
         end
         next_st.bresp   = d.hit ? RESP_OKAY : RESP_SLVERR;
         next_st.bvalid  = 1'b1;
         next_st.aw_full = 1'b0;
         next_st.w_full  = 1'b0;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st.arready) begin
         d              = ppr_decode(32'(s_axi_araddr));
         next_st.rdata  = d.hit ? 32'(st.regs[d.idx]) : '0;
         next_st.rresp  = d.hit ? RESP_OKAY : RESP_SLVERR;
         next_st.rvalid = 1'b1;
      end
      next_st.awready = !next_st.aw_full && !next_st.bvalid;
      next_st.wready  = !next_st.w_full && !next_st.bvalid;
      next_st.arready = !next_st.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st      <= '0;
         st.regs <= {PPR_NREGS{REG_RESET}};
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign route         = st.regs;

endmodule : ppr_axil_slave

/* hdl/ppr_pin_route_mux.sv */
/*
 * Peripheral pin route multiplexer: places peripheral signals on their
 * default pin, an alternate pin, or no pin, per the routing registers.
 * Assumes peripherals share aclk; pin inputs are asynchronous.
 */
// Behaviour
// - Each routed signal keeps default pin or moves to alternate; serial port and SPI signals can also disconnect.
// - Event output B goes to PB2 when bit 1 clear, PB7 when set.
// - Event output A goes to PA2 when bit 0 clear, PA7 when set.
// - Table 3 output on PC4 or PA5; inputs stay on PC0..PC2.
// - Table 2 output on PB3 or PB6; inputs stay on PB0..PB2.
// - Table 1 output on PA7 or PC1; inputs stay on PC3..PC5.
// - Table 0 output on PA4 or PB4; inputs stay on PA0..PA2.
// - Second serial port uses PA1..PA4 at 0, PC2,PC1,PC0,PC3 at 1.
// - Second serial port code 3 disconnects; code 2 reserved, not written.
// - First serial port uses PB2,PB3,PB1,PB0 at 0, PA1..PA4 at 1; 3 disconnects.
// - SPI uses PA1..PA4 at 0, PC2,PC1,PC0,PC3 at 1; 3 disconnects.
// - Timer A outputs 0..5 on PB0..PB2,PA3..PA5, or PB3..PB5,PC3..PC5.
// - Timer B0 on PA5 or PC0, timer B1 on PA3 or PC4.
module ppr_pin_route_mux
   import ppr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Register bus.
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [PPR_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [PPR_DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Event outputs, index 0 is A.
   input  wire logic [1:0]            event_output,
   input  wire logic [1:0]            event_output_en,
   // Custom logic unit lookup tables.
   input  wire logic [3:0]            lookup_table_out,
   input  wire logic [3:0]            lookup_table_out_en,
   output logic [3:0][2:0]            lookup_table_in,
   // Serial ports, index 0 is the first.
   input  wire logic [1:0]            serial_port_txd,
   input  wire logic [1:0]            serial_port_txd_en,
   output logic [1:0]                 serial_port_rxd,
   input  wire logic [1:0]            serial_clock_pin_out,
   input  wire logic [1:0]            serial_clock_pin_oe,
   output logic [1:0]                 serial_clock_pin_in,
   input  wire logic [1:0]            transceiver_direction,
   input  wire logic [1:0]            transceiver_direction_en,
   // SPI.
   input  wire logic                  spi_mosi_out,
   input  wire logic                  spi_mosi_oe,
   output logic                       spi_mosi_in,
   input  wire logic                  spi_miso_out,
   input  wire logic                  spi_miso_oe,
   output logic                       spi_miso_in,
   input  wire logic                  spi_sck_out,
   input  wire logic                  spi_sck_oe,
   output logic                       spi_sck_in,
   output logic                       spi_ss_in,
   // Timers.
   input  wire logic [N_TMRA-1:0]     timer_a_waveform_output,
   input  wire logic [N_TMRA-1:0]     timer_a_waveform_output_en,
   input  wire logic                  timer_b0_waveform_output,
   input  wire logic                  timer_b0_waveform_output_en,
   input  wire logic                  timer_b1_waveform_output,
   input  wire logic                  timer_b1_waveform_output_en,
   // Pins, bit 0 is PA0, bit 8 PB0, bit 16 PC0.
   input  wire logic [PPR_NPINS-1:0]  pin_in,
   output logic [PPR_NPINS-1:0]       pin_out,
   output logic [PPR_NPINS-1:0]       pin_oe
);

   // ************************************************************
   // Register file.
   // ************************************************************
   logic [PPR_NREGS-1:0][7:0] route;

   ppr_axil_slave #(
      .ADDR_W (ADDR_W)
   ) u_regs (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .route         (route)
   );

   // ************************************************************
   // State.
   // ************************************************************
   typedef struct packed {
      logic [PPR_NPINS-1:0] sync1;
      logic [PPR_NPINS-1:0] sync2;
      logic [PPR_NPINS-1:0] pout;
      logic [PPR_NPINS-1:0] poe;
      logic [3:0][2:0]      lut_in;
      logic [1:0]           rxd;
      logic [1:0]           xck_in;
      logic                 mosi_in;
      logic                 miso_in;
      logic                 sck_in;
      logic                 ss_in;
   } ppr_mux_t;

   ppr_mux_t st;
   ppr_mux_t next_st;

   // ************************************************************
   // Routing.
   // ************************************************************
   // A disabled signal leaves its pin alone, so an idle peripheral cannot steal it.
   function automatic logic [2*PPR_NPINS-1:0] drive(input logic [2*PPR_NPINS-1:0] oe, input ppr_pin_t id,
                                                    input logic v, input logic en);
      return en ? {ppr_set(oe[2*PPR_NPINS-1:PPR_NPINS], id, v), ppr_set(oe[PPR_NPINS-1:0], id, 1'b1)} : oe;
   endfunction : drive

   // Where two enabled signals land on one pin, the later one below wins;
   // software is expected to avoid such overlaps.
   always_comb begin
      logic [PPR_NPINS-1:0] o;
      logic [PPR_NPINS-1:0] e;
      logic [1:0]           code;
      logic                 pos;
      logic                 conn;
      o       = '0;
      e       = '0;
      code    = ROUTE_DEFAULT;
      pos     = 1'b0;
      conn    = 1'b0;
      next_st = st;
      next_st.sync1 = pin_in;
      next_st.sync2 = st.sync1;
      for (int i = 0; i < 2; i++) begin
         pos = route[REG_EVENT_OUTPUT_ROUTE][i];
         {o, e} = drive({o, e}, EV_PINS[pos][i], event_output[i], event_output_en[i]);
      end
      for (int i = 0; i < 4; i++) begin
         pos = route[REG_LOGIC_TABLE_ROUTE][i];
         {o, e} = drive({o, e}, LUT_OUT_PINS[pos][i], lookup_table_out[i], lookup_table_out_en[i]);
         for (int j = 0; j < 3; j++) begin
            next_st.lut_in[i][j] = st.sync2[LUT_IN_PINS[i][j]];
         end
      end
      for (int k = 0; k < 2; k++) begin
         code = route[REG_SERIAL_PORT_ROUTE][k*SER_FIELD_W +: SER_FIELD_W];
         // The reserved code is treated like no connection, the safe choice.
         conn = (code == ROUTE_DEFAULT) || (code == ROUTE_ALT);
         pos  = code[0];
         if (conn) begin
            {o, e} = drive({o, e}, SER_PINS[k][pos][SIG_TX], serial_port_txd[k], serial_port_txd_en[k]);
            {o, e} = drive({o, e}, SER_PINS[k][pos][SIG_CK], serial_clock_pin_out[k], serial_clock_pin_oe[k]);
            {o, e} = drive({o, e}, SER_PINS[k][pos][SIG_DIR], transceiver_direction[k],
                           transceiver_direction_en[k]);
         end
         next_st.rxd[k]    = conn & st.sync2[SER_PINS[k][pos][SIG_RX]];
         next_st.xck_in[k] = conn & st.sync2[SER_PINS[k][pos][SIG_CK]];
      end
      code = route[REG_SPI_ROUTE][SPI_LSB +: SER_FIELD_W];
      conn = (code == ROUTE_DEFAULT) || (code == ROUTE_ALT);
      pos  = code[0];
      if (conn) begin
         {o, e} = drive({o, e}, SPI_PINS[pos][SIG_TX], spi_mosi_out, spi_mosi_oe);
         {o, e} = drive({o, e}, SPI_PINS[pos][SIG_RX], spi_miso_out, spi_miso_oe);
         {o, e} = drive({o, e}, SPI_PINS[pos][SIG_CK], spi_sck_out, spi_sck_oe);
      end
      next_st.mosi_in = conn & st.sync2[SPI_PINS[pos][SIG_TX]];
      next_st.miso_in = conn & st.sync2[SPI_PINS[pos][SIG_RX]];
      next_st.sck_in  = conn & st.sync2[SPI_PINS[pos][SIG_CK]];
      // A disconnected slave select reads high, so the port stays deselected.
      next_st.ss_in   = !conn | st.sync2[SPI_PINS[pos][SIG_DIR]];
      for (int i = 0; i < N_TMRA; i++) begin
         pos = route[REG_TIMER_A_ROUTE][i];
         {o, e} = drive({o, e}, TMRA_PINS[pos][i], timer_a_waveform_output[i], timer_a_waveform_output_en[i]);
      end
      pos = route[REG_TIMER_B_ROUTE][0];
      {o, e} = drive({o, e}, TMRB_PINS[pos][0], timer_b0_waveform_output, timer_b0_waveform_output_en);
      pos = route[REG_TIMER_B_ROUTE][1];
      {o, e} = drive({o, e}, TMRB_PINS[pos][1], timer_b1_waveform_output, timer_b1_waveform_output_en);
      next_st.pout = o & e;
      next_st.poe  = e;
   end

   // Registered outputs: a write reaches the pins one edge later.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st       <= '0;
         st.ss_in <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // Outputs.
   // ************************************************************
   assign pin_out             = st.pout;
   assign pin_oe              = st.poe;
   assign lookup_table_in     = st.lut_in;
   assign serial_port_rxd     = st.rxd;
   assign serial_clock_pin_in = st.xck_in;
   assign spi_mosi_in         = st.mosi_in;
   assign spi_miso_in         = st.miso_in;
   assign spi_sck_in          = st.sck_in;
   assign spi_ss_in           = st.ss_in;

endmodule : ppr_pin_route_mux

/* dv/ppr_pin_model.sv */
/* Pin model for the far side: driven pins echo, released pins read ext.
   Assumes one clock; one flop stands for pad and wiring delay. */
module ppr_pin_model (
   // Clock and bench level.
   input  logic        aclk,
   input  logic        ext,
   // Pins.
   input  logic [23:0] pin_out,
   input  logic [23:0] pin_oe,
   output logic [23:0] pin_in
);
   // A released pin takes the level the bench chooses, as a pull would.
   always_ff @(posedge aclk) begin
      pin_in <= (pin_out & pin_oe) | ({24{ext}} & ~pin_oe);
   end
endmodule : ppr_pin_model

/* dv/ppr_pin_route_mux_properties.sv */
/* Checker for bus answer timing, pin gating and fixed table inputs.
   Assumes it sees only the top ports; bound after the module. */
module ppr_pin_route_mux_properties
   import ppr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock, reset and bus.
   input logic                  aclk,
   input logic                  aresetn,
   input logic                  s_axi_awvalid,
   input logic                  s_axi_awready,
   input logic                  s_axi_wvalid,
   input logic                  s_axi_wready,
   input logic [1:0]            s_axi_bresp,
   input logic                  s_axi_bvalid,
   input logic                  s_axi_bready,
   input logic [ADDR_W-1:0]     s_axi_araddr,
   input logic                  s_axi_arvalid,
   input logic                  s_axi_arready,
   input logic [PPR_DATA_W-1:0] s_axi_rdata,
   input logic [1:0]            s_axi_rresp,
   input logic                  s_axi_rvalid,
   input logic                  s_axi_rready,
   // Pins.
   input logic [3:0][2:0]       lookup_table_in,
   input logic [PPR_NPINS-1:0]  pin_in,
   input logic [PPR_NPINS-1:0]  pin_out,
   input logic [PPR_NPINS-1:0]  pin_oe
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Input checks wait out the two sync flops after reset.
   logic [2:0] up;
   always_ff @(posedge aclk) begin
      if (!aresetn) up <= 3'h0;
      else if (up != 3'h4) up <= up + 3'h1;
   end
   sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
   a_wr_answer: assert property (s_wr |=> s_axi_bvalid) else $error("bvalid late");
   a_rd_answer: assert property (s_rd |=> s_axi_rvalid) else $error("rvalid late");
   a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp dropped");
   a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata dropped");
   a_rd_unmapped: assert property (s_rd and s_axi_araddr >= 'h18 |=> s_axi_rresp == RESP_SLVERR
      && s_axi_rdata == 32'h0) else $error("unmapped read");
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> pin_oe == 24'h0)
      else $error("pin driven in reset");
   a_out_gated: assert property ((pin_out & ~pin_oe) == 24'h0) else $error("pin out ungated");
   a_lookup_table_0_in: assert property (up == 3'h4 |-> lookup_table_in[0] == $past(pin_in[2:0], 3))
      else $error("table 0 input pins");
   a_lookup_table_1_in: assert property (up == 3'h4 |-> lookup_table_in[1] == $past(pin_in[21:19], 3))
      else $error("table 1 input pins");
   a_lookup_table_2_in: assert property (up == 3'h4 |-> lookup_table_in[2] == $past(pin_in[10:8], 3))
      else $error("table 2 input pins");
   a_lookup_table_3_in: assert property (up == 3'h4 |-> lookup_table_in[3] == $past(pin_in[18:16], 3))
      else $error("table 3 input pins");
endmodule : ppr_pin_route_mux_properties
bind ppr_pin_route_mux ppr_pin_route_mux_properties #(.ADDR_W(ADDR_W)) ppr_pin_route_mux_properties_i (.*);

/* dv/ppr_pin_route_mux_tb.sv */
/* Self-checking bench for the pin route multiplexer.
   Assumes ppr_pin_model on the pins; peripheral value equals its enable. */
module ppr_pin_route_mux_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ppr_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, ext = 1'b0, miso_i, ss_i, mosi_i, sck_i;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [22:0] pe = 23'h0;
   logic [1:0]  bresp, rresp, rxd, xck_i;
   logic [3:0][2:0] lin;
   logic [23:0] pin_in, pin_out, pin_oe;
   int          err_total = 0, n_tests = 0, cyc = 0;
   always #4 aclk = ~aclk;
   ppr_pin_route_mux ppr_pin_route_mux_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .event_output(pe[1:0]), .event_output_en(pe[1:0]),
      .lookup_table_out(pe[5:2]), .lookup_table_out_en(pe[5:2]), .lookup_table_in(lin),
      .serial_port_txd(pe[7:6]), .serial_port_txd_en(pe[7:6]), .serial_port_rxd(rxd),
      .serial_clock_pin_out(pe[9:8]), .serial_clock_pin_oe(pe[9:8]), .serial_clock_pin_in(xck_i),
      .transceiver_direction(pe[11:10]), .transceiver_direction_en(pe[11:10]),
      .spi_mosi_out(pe[12]), .spi_mosi_oe(pe[12]), .spi_mosi_in(mosi_i), .spi_miso_out(pe[13]),
      .spi_miso_oe(pe[13]), .spi_miso_in(miso_i), .spi_sck_out(pe[14]), .spi_sck_oe(pe[14]),
      .spi_sck_in(sck_i), .spi_ss_in(ss_i), .timer_a_waveform_output(pe[20:15]),
      .timer_a_waveform_output_en(pe[20:15]), .timer_b0_waveform_output(pe[21]),
      .timer_b0_waveform_output_en(pe[21]), .timer_b1_waveform_output(pe[22]),
      .timer_b1_waveform_output_en(pe[22]), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   ppr_pin_model ppr_pin_model_i (.aclk(aclk), .ext(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
   task print_verdict;
      $display("checks %0d bad %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Ready rises a cycle late, so the slave must hold its answer.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa = 1'b1, pw = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (pa || pw) begin
         @(posedge aclk);
         if (pa && awready) begin
            pa = 1'b0;
            awvalid <= 1'b0;
         end
         if (pw && wready) begin
            pw = 1'b0;
            wvalid <= 1'b0;
         end
      end
      @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      chk(rdata, ed);
      chk(32'(rresp), 32'(er));
      @(posedge aclk);
   endtask : rd
   task automatic rc(input int i, input logic [7:0] v, input logic [22:0] p, input logic [23:0] e);
      wr(8'(i * 4), 32'(v), RESP_OKAY);
      pe <= p;
      repeat (3) @(posedge aclk);
      chk(32'(pin_oe), 32'(e));
      chk(32'(pin_out), 32'(e));
   endtask : rc
   task t_regs;
      for (int i = 0; i < PPR_NREGS; i++) begin
         rd(8'(i * 4), 32'h0, RESP_OKAY);
         wr(8'(i * 4), 32'hff, RESP_OKAY);
         rd(8'(i * 4), 32'(REG_MASK[i]), RESP_OKAY);
         wr(8'(i * 4), 32'h0, RESP_OKAY);
      end
      wr(8'h18, 32'hff, RESP_SLVERR);
      rd(8'h18, 32'h0, RESP_SLVERR);
      $display("regs done");
   endtask : t_regs
   // Reserved code 2 is never written.
   task t_inputs;
      repeat (5) @(posedge aclk);
      chk(32'({rxd, xck_i, ss_i, mosi_i, sck_i}), 32'h0);
      ext <= 1'b1;
      repeat (5) @(posedge aclk);
      chk(32'({rxd, xck_i, ss_i, mosi_i, sck_i, lin}), 32'h7ffff);
      wr(8'h08, 32'hf, RESP_OKAY);
      wr(8'h0c, 32'h3, RESP_OKAY);
      repeat (5) @(posedge aclk);
      chk(32'({rxd, xck_i, ss_i, mosi_i, miso_i, sck_i, lin}), 32'h8fff);
      wr(8'h08, 32'h0, RESP_OKAY);
      wr(8'h0c, 32'h0, RESP_OKAY);
      $display("inputs done");
   endtask : t_inputs
   task t_outputs;
      rc(0, 8'h0, 23'h3, 24'h000404);
      rc(0, 8'h1, 23'h3, 24'h000480);
      rc(0, 8'h2, 23'h3, 24'h008004);
      rc(1, 8'h0, 23'h3c, 24'h100890);
      rc(1, 8'hf, 23'h3c, 24'h025020);
      rc(1, 8'h5, 23'h3c, 24'h105080);
      rc(2, 8'h0, 23'h540, 24'h000700);
      rc(2, 8'h1, 23'h540, 24'h00001a);
      rc(2, 8'h3, 23'h540, 24'h0);
      rc(2, 8'h0, 23'ha80, 24'h00001a);
      rc(2, 8'h4, 23'ha80, 24'h0d0000);
      rc(2, 8'hc, 23'ha80, 24'h0);
      rc(3, 8'h0, 23'h7000, 24'h00000e);
      rc(3, 8'h1, 23'h7000, 24'h070000);
      rc(3, 8'h3, 23'h7000, 24'h0);
      rc(4, 8'h0, 23'h1f8000, 24'h000738);
      rc(4, 8'h3f, 23'h1f8000, 24'h383800);
      rc(4, 8'h15, 23'h1f8000, 24'h102a28);
      rc(5, 8'h0, 23'h600000, 24'h000028);
      rc(5, 8'h1, 23'h600000, 24'h010008);
      rc(5, 8'h3, 23'h600000, 24'h110000);
      $display("outputs done");
   endtask : t_outputs
   task t_reset;
      rc(0, 8'h3, 23'h3, 24'h008080);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h0, 32'h0, RESP_OKAY);
      chk(32'(pin_oe), 32'h000404);
      $display("reset done");
   endtask : t_reset
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_inputs();
      t_outputs();
      t_reset();
      print_verdict();
   end
endmodule : ppr_pin_route_mux_tb
